// *** src/nbc_pkg.sv ***
package nbc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices as numbered in the header map; byte address is index times four.
  localparam logic [11:0] IDX_COMMAND    = 12'h004;
  localparam logic [11:0] IDX_STATUS     = 12'h006;
  localparam logic [11:0] IDX_REVISION   = 12'h008;
  localparam logic [11:0] IDX_CLASS      = 12'h009;
  localparam logic [11:0] IDX_LINE_SIZE  = 12'h00c;
  localparam logic [11:0] IDX_LATENCY    = 12'h00d;
  localparam logic [11:0] IDX_REV_LOCK   = 12'h020;

  // Byte addresses seen on the APB.
  localparam logic [11:0] ADDR_COMMAND   = IDX_COMMAND << 2;
  localparam logic [11:0] ADDR_STATUS    = IDX_STATUS << 2;
  localparam logic [11:0] ADDR_REVISION  = IDX_REVISION << 2;
  localparam logic [11:0] ADDR_CLASS     = IDX_CLASS << 2;
  localparam logic [11:0] ADDR_LINE_SIZE = IDX_LINE_SIZE << 2;
  localparam logic [11:0] ADDR_LATENCY   = IDX_LATENCY << 2;
  localparam logic [11:0] ADDR_REV_LOCK  = IDX_REV_LOCK << 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Command register field positions and reset values.
  localparam int unsigned CMD_PARITY_REPORT_BIT = 6;
  localparam int unsigned CMD_SYSTEM_ERROR_BIT  = 8;
  localparam logic        CMD_ENABLE_RESET      = 1'b0;

  // Status register field positions.
  localparam int unsigned STS_IRQ_PENDING_BIT   = 3;
  localparam int unsigned STS_CAP_CHAIN_BIT     = 4;
  localparam int unsigned STS_POISON_SEEN_BIT   = 8;
  localparam int unsigned STS_SYSERR_SENT_BIT   = 14;
  localparam int unsigned STS_PARITY_DET_BIT    = 15;
  localparam logic        STS_CAP_CHAIN_VALUE   = 1'b1;
  localparam logic        STS_IRQ_PENDING_VALUE = 1'b0;

  // Sticky flag slots inside the flag bank.
  localparam int unsigned FLAG_COUNT        = 3;
  localparam int unsigned FLAG_POISON_SEEN  = 0;
  localparam int unsigned FLAG_SYSERR_SENT  = 1;
  localparam int unsigned FLAG_PARITY_DET   = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Class code bytes and other fixed or reset values.
  localparam logic [7:0] CLASS_BASE        = 8'h06;
  localparam logic [7:0] CLASS_SUB         = 8'h04;
  localparam logic [7:0] CLASS_PROG_IF     = 8'h00;
  localparam logic [7:0] LINE_SIZE_RESET   = 8'h00;
  localparam logic [7:0] LATENCY_VALUE     = 8'h00;
  localparam int unsigned REV_LOCK_BIT     = 0;
  localparam logic       REV_LOCK_RESET    = 1'b0;

endpackage

// *** src/nbc_sticky_flags.sv ***
`timescale 1ns/100ps
`default_nettype none

module nbc_sticky_flags #(
  parameter int unsigned N = 3
) (
  // Clock and reset.
  input  wire logic         core_clk,
  input  wire logic         rst,
  // Hardware events and software clear mask.
  input  wire logic [N-1:0] set_pulse,
  input  wire logic [N-1:0] clear_mask,
  // Current flag values.
  output var  logic [N-1:0] flags
);

  typedef struct packed {
    logic [N-1:0] flags;
  } nbc_flag_state_s;

  nbc_flag_state_s state_q;
  nbc_flag_state_s state_d;

  ////////////////////////////////////////////////////////////////////////////////
  // A set in the same cycle as a clear wins, so no event is lost to a racing clear.
  always_comb begin
    state_d       = state_q;
    state_d.flags = (state_q.flags & ~clear_mask) | set_pulse;
  end

  // Flags come up clear after reset.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign flags = state_q.flags;

endmodule

`default_nettype wire

// *** src/nbc_bridge_header.sv ***
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Interrupt-pending status bit 3 always reads zero, downstream interrupts ignored.
// - Status bit 4 reads a fixed one for the capability chain; writes ignored.
// - Status bit 8 sets on poisoned completion or write when parity reporting enabled.
// - Status bit 14 sets on sent fatal/non-fatal message with system error enabled.
// - Status bit 15 sets on any poisoned packet received, regardless of enables.
// - On downstream ports, internal parity errors also set status bit 15.
// - Reserved, speed, back-to-back, select timing and abort bits read zero, ignore writes.
// - Eight-bit revision number at index 0x008, writable only while unlocked.
// - Class code reads base 0x06 and sub class 0x04, read only.
// - Programming interface byte of the class code reads zero.
// - Line size byte is plain read/write storage resetting to zero.
// - Primary latency byte reads zero and ignores writes.
// - Command bit 6 enables parity reporting; cleared, status bit 8 never sets.
// - Command bit 8 enables system error reporting gating status bit 14.
module nbc_bridge_header #(
  parameter logic [7:0] REVISION_DEFAULT = 8'h00  // Arbitrary value.
) (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rst,
  // APB slave.
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Error events from the bridge datapath, one-cycle pulses.
  input  wire logic        rx_poisoned_cpl_or_write,
  input  wire logic        rx_poisoned_any,
  input  wire logic        err_msg_sent,
  input  wire logic        internal_parity_err,
  // Port role strap, high on a downstream port.
  input  wire logic        downstream_port,
  // Enables handed to the rest of the bridge.
  output var  logic        parity_report_enable,
  output var  logic        system_error_enable
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register map as seen on the APB, byte addresses.
  //   0x010 command: bit 6 parity reporting, bit 8 system error reporting.
  //   0x018 status: bit 4 fixed one, bits 8, 14 and 15 cleared by writing one.
  //   0x020 revision number in bits 7:0, frozen while the lock bit is set.
  //   0x024 class code in bits 23:0, read only.
  //   0x030 line size scratch byte in bits 7:0.
  //   0x034 primary latency byte, always zero.
  //   0x080 revision lock in bit 0; it resets unlocked.
  // Any other address answers with pslverr and changes nothing.
  // Bits that carry no field read zero, and writes to them are dropped.

  // Bus timing: every transfer is answered in its first access cycle, with no
  // wait state, so a master never stalls on this bank.
  // Read data is taken at the setup edge; a flag that sets during the access
  // cycle is seen by the next read instead, so polling software loses nothing.
  // A write lands at the access edge that the master samples, never before.
  // Back-to-back transfers are fine: a setup may follow an access edge at once.

  // Error events, one-cycle pulses on the core clock:
  //   poisoned completion or write: status bit 8 when enabled, bit 15 always.
  //   any poisoned packet: status bit 15.
  //   error message sent: status bit 14 while system error reporting is on.
  //   internal parity error: status bit 15, on a downstream port only.
  // A pulse that meets a clearing write in the same cycle keeps its flag set.
  // The status flags come up clear after reset.

  // Limitations:
  //   Only bits 6 and 8 of the command word are kept; its other bits read zero.
  //   A write with every strobe low is answered but changes nothing.
  //   The port role strap is read directly and must be steady on the core clock.
  //   The revision number holds its default until software writes it unlocked.
  //   Unmapped reads return zero data along with the error.
  //   The class code and latency byte are constants; no strap can change them.
  //   Nothing here raises an interrupt; software polls the status word.

  ////////////////////////////////////////////////////////////////////////////////
  // Block state.

  typedef struct packed {
    logic        parity_report_enable;
    logic        system_error_enable;
    logic [7:0]  revision_number;
    logic        revision_lock;
    logic [7:0]  line_size_scratch;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } nbc_state_s;

  nbc_state_s                          state_q;
  nbc_state_s                          state_d;
  logic [nbc_pkg::FLAG_COUNT-1:0]      flag_set;
  logic [nbc_pkg::FLAG_COUNT-1:0]      flag_clear;
  logic [nbc_pkg::FLAG_COUNT-1:0]      flags;
  logic                                setup_phase;
  logic                                write_fire;

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // True when the byte address names a register of this block.
  function automatic logic addr_mapped(input logic [11:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr)
      nbc_pkg::ADDR_COMMAND,
      nbc_pkg::ADDR_STATUS,
      nbc_pkg::ADDR_REVISION,
      nbc_pkg::ADDR_CLASS,
      nbc_pkg::ADDR_LINE_SIZE,
      nbc_pkg::ADDR_LATENCY,
      nbc_pkg::ADDR_REV_LOCK: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // Merge one byte of write data into an old byte when its strobe is set.
  function automatic logic [7:0] merge_byte(input logic [7:0] old_val,
                                            input logic [7:0] new_val,
                                            input logic       strobe);
    logic [7:0] res;
    res = strobe ? new_val : old_val;
    return res;
  endfunction

  // Assemble the status word from fixed bits and the sticky flags.
  function automatic logic [15:0] status_word(input logic [nbc_pkg::FLAG_COUNT-1:0] f);
    logic [15:0] w;
    w = 16'h0000;
    w[nbc_pkg::STS_IRQ_PENDING_BIT] = nbc_pkg::STS_IRQ_PENDING_VALUE;
    w[nbc_pkg::STS_CAP_CHAIN_BIT]   = nbc_pkg::STS_CAP_CHAIN_VALUE;
    w[nbc_pkg::STS_POISON_SEEN_BIT] = f[nbc_pkg::FLAG_POISON_SEEN];
    w[nbc_pkg::STS_SYSERR_SENT_BIT] = f[nbc_pkg::FLAG_SYSERR_SENT];
    w[nbc_pkg::STS_PARITY_DET_BIT]  = f[nbc_pkg::FLAG_PARITY_DET];
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus phase decode.

  // The slave answers in the first access cycle, so a write lands when the master sees pready.
  assign setup_phase = psel & ~penable;
  assign write_fire  = psel & penable & pwrite & state_q.pready & ~state_q.pslverr;

  ////////////////////////////////////////////////////////////////////////////////
  // Error events into the sticky flags.

  // Poisoned completions and writes set status bit 8 only while parity reporting is on; they set bit 15 always.
  always_comb begin
    flag_set = '0;
    flag_set[nbc_pkg::FLAG_POISON_SEEN] = rx_poisoned_cpl_or_write
                                          & state_q.parity_report_enable;
    flag_set[nbc_pkg::FLAG_SYSERR_SENT] = err_msg_sent
                                          & state_q.system_error_enable;
    flag_set[nbc_pkg::FLAG_PARITY_DET]  = rx_poisoned_any | rx_poisoned_cpl_or_write
                                          | (internal_parity_err & downstream_port);
  end

  // Writing one to a flag bit clears it; only the upper status byte holds flags.
  always_comb begin
    flag_clear = '0;
    if (write_fire && paddr == nbc_pkg::ADDR_STATUS && pstrb[1]) begin
      flag_clear[nbc_pkg::FLAG_POISON_SEEN] = pwdata[nbc_pkg::STS_POISON_SEEN_BIT];
      flag_clear[nbc_pkg::FLAG_SYSERR_SENT] = pwdata[nbc_pkg::STS_SYSERR_SENT_BIT];
      flag_clear[nbc_pkg::FLAG_PARITY_DET]  = pwdata[nbc_pkg::STS_PARITY_DET_BIT];
    end
  end

  nbc_sticky_flags #(
    .N          (nbc_pkg::FLAG_COUNT)
  ) u_flags (
    .core_clk   (core_clk),
    .rst        (rst),
    .set_pulse  (flag_set),
    .clear_mask (flag_clear),
    .flags      (flags)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic for registers and the bus answer.

  // Read data is captured in the setup cycle; a flag that sets in the access cycle shows on the next read.
  always_comb begin
    state_d         = state_q;
    state_d.pready  = 1'b0;
    state_d.pslverr = 1'b0;
    state_d.prdata  = 32'h0000_0000;

    // Setup cycle: decode and prepare the one-cycle answer.
    if (setup_phase) begin
      state_d.pready  = 1'b1;
      state_d.pslverr = ~addr_mapped(paddr);
      if (!pwrite) begin
        case (paddr)
          nbc_pkg::ADDR_COMMAND: begin
            state_d.prdata[nbc_pkg::CMD_PARITY_REPORT_BIT] = state_q.parity_report_enable;
            state_d.prdata[nbc_pkg::CMD_SYSTEM_ERROR_BIT]  = state_q.system_error_enable;
          end
          nbc_pkg::ADDR_STATUS: begin
            state_d.prdata[15:0] = status_word(flags);
          end
          nbc_pkg::ADDR_REVISION: begin
            state_d.prdata[7:0] = state_q.revision_number;
          end
          nbc_pkg::ADDR_CLASS: begin
            state_d.prdata[23:0] = {nbc_pkg::CLASS_BASE, nbc_pkg::CLASS_SUB,
                                    nbc_pkg::CLASS_PROG_IF};
          end
          nbc_pkg::ADDR_LINE_SIZE: begin
            state_d.prdata[7:0] = state_q.line_size_scratch;
          end
          nbc_pkg::ADDR_LATENCY: begin
            state_d.prdata[7:0] = nbc_pkg::LATENCY_VALUE;
          end
          nbc_pkg::ADDR_REV_LOCK: begin
            state_d.prdata[nbc_pkg::REV_LOCK_BIT] = state_q.revision_lock;
          end
          default: begin
            state_d.prdata = 32'h0000_0000;
          end
        endcase
      end
    end

    // Access edge: writes take effect, byte by byte; read-only words ignore them.
    if (write_fire) begin
      case (paddr)
        nbc_pkg::ADDR_COMMAND: begin
          if (pstrb[0]) begin
            state_d.parity_report_enable = pwdata[nbc_pkg::CMD_PARITY_REPORT_BIT];
          end
          if (pstrb[1]) begin
            state_d.system_error_enable = pwdata[nbc_pkg::CMD_SYSTEM_ERROR_BIT];
          end
        end
        nbc_pkg::ADDR_REVISION: begin
          if (!state_q.revision_lock) begin
            state_d.revision_number = merge_byte(state_q.revision_number,
                                                 pwdata[7:0], pstrb[0]);
          end
        end
        nbc_pkg::ADDR_LINE_SIZE: begin
          state_d.line_size_scratch = merge_byte(state_q.line_size_scratch,
                                                 pwdata[7:0], pstrb[0]);
        end
        nbc_pkg::ADDR_REV_LOCK: begin
          if (pstrb[0]) begin
            state_d.revision_lock = pwdata[nbc_pkg::REV_LOCK_BIT];
          end
        end
        default: begin
          state_d.revision_lock = state_q.revision_lock;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  // Enables start off so no error is reported before software configures the port.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q.parity_report_enable <= nbc_pkg::CMD_ENABLE_RESET;
      state_q.system_error_enable  <= nbc_pkg::CMD_ENABLE_RESET;
      state_q.revision_number      <= REVISION_DEFAULT;
      state_q.revision_lock        <= nbc_pkg::REV_LOCK_RESET;
      state_q.line_size_scratch    <= nbc_pkg::LINE_SIZE_RESET;
      state_q.pready               <= 1'b0;
      state_q.pslverr              <= 1'b0;
      state_q.prdata               <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop.

  assign prdata               = state_q.prdata;
  assign pready               = state_q.pready;
  assign pslverr              = state_q.pslverr;
  assign parity_report_enable = state_q.parity_report_enable;
  assign system_error_enable  = state_q.system_error_enable;

endmodule

`default_nettype wire

// *** dv/nbc_header_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
// Watches the APB answer and the enables of the header bank.
module nbc_header_checker (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        rst,
  // APB slave.
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Enables.
  input wire logic        parity_report_enable,
  input wire logic        system_error_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // A read in its access cycle, the moment the answer is judged.
  logic rd_acc;
  assign rd_acc = psel && penable && pready && !pwrite;

  a_ready_one_shot: assert property (pready |=> !pready) else $error("pready held too long");
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no answer after setup");
  a_ready_has_cause: assert property (pready |-> $past(psel && !penable)) else $error("pready without setup");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_class_fixed: assert property (
    rd_acc && paddr == 12'h024 |-> prdata == 32'h00060400 && !pslverr) else $error("class code wrong");
  a_status_fixed: assert property (
    rd_acc && paddr == 12'h018 |-> (prdata & 32'hffff3eff) == 32'h10) else $error("status fixed bits wrong");
  a_latency_zero: assert property (
    rd_acc && paddr == 12'h034 |-> prdata == 32'h0) else $error("latency not zero");
  a_parity_en_cause: assert property ($changed(parity_report_enable) |->
    $past(psel && penable && pready && pwrite && paddr == 12'h010 && pstrb[0])) else $error("parity enable moved");
  a_syserr_en_cause: assert property ($changed(system_error_enable) |->
    $past(psel && penable && pready && pwrite && paddr == 12'h010 && pstrb[1])) else $error("syserr enable moved");
endmodule

bind nbc_bridge_header nbc_header_checker u_chk (.core_clk, .rst, .paddr, .psel, .penable, .pwrite, .pstrb,
  .prdata, .pready, .pslverr, .parity_report_enable, .system_error_enable);
`default_nettype wire

// *** dv/test_bridge_config_status_header.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_bridge_config_status_header;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [3:0]  s;
    logic [31:0] e;
    logic        r;
  } nbc_row_s;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] paddr = 12'h0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [3:0]  ev_q = 4'h0;
  logic        ds_q = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pre;
  logic        see;
  logic [31:0] rd;
  logic        er;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  nbc_row_s    rows [8];

  nbc_bridge_header u_dut (.core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_poisoned_cpl_or_write(ev_q[3]), .rx_poisoned_any(ev_q[2]), .err_msg_sent(ev_q[1]),
    .internal_parity_err(ev_q[0]), .downstream_port(ds_q), .parity_report_enable(pre), .system_error_enable(see));

  ////////////////////////////////////////
  // Free-running 200 MHz clock.
  initial forever #2.5 core_clk = ~core_clk;

  // A hung handshake must still reach the verdict, so cap the run.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask

  // One-cycle pulse on the event inputs: cpl_or_write, any, err_msg, internal.
  task automatic pulse(input logic [3:0] m);
    @(posedge core_clk);
    ev_q <= m;
    @(posedge core_clk);
    ev_q <= 4'h0;
  endtask

  task automatic clr;
    apb(1'b1, 12'h018, 32'h0000c100, 4'h2);
    rchk(12'h018, 32'h10);
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////
  // Main sequence: reset values, the row table, then event cases.
  initial begin
    rows[0] = '{12'h030, 32'ha5, 4'h1, 32'ha5, 1'b0};
    rows[1] = '{12'h030, 32'hff, 4'h0, 32'ha5, 1'b0};
    rows[2] = '{12'h018, 32'hffffffff, 4'hf, 32'h10, 1'b0};
    rows[3] = '{12'h024, 32'hffffffff, 4'hf, 32'h00060400, 1'b0};
    rows[4] = '{12'h034, 32'hff, 4'h1, 32'h0, 1'b0};
    rows[5] = '{12'h010, 32'h140, 4'h3, 32'h140, 1'b0};
    rows[6] = '{12'h020, 32'h3c, 4'h1, 32'h3c, 1'b0};
    rows[7] = '{12'h0fc, 32'h1, 4'hf, 32'h0, 1'b1};
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rchk(12'h018, 32'h10);
    rchk(12'h030, 32'h0);
    rchk(12'h010, 32'h0);
    rchk(12'h020, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
      rchk(rows[i].a, rows[i].e);
      chk("slave error", {31'h0, rows[i].r}, {31'h0, er});
    end
    chk("enables", 32'h3, {30'h0, see, pre});
    $display("test table done");
    pulse(4'h8);
    rchk(12'h018, 32'h8110);
    apb(1'b1, 12'h018, 32'hffff, 4'h1);
    rchk(12'h018, 32'h8110);
    clr();
    pulse(4'h2);
    rchk(12'h018, 32'h4010);
    clr();
    apb(1'b1, 12'h010, 32'h0, 4'h3);
    pulse(4'ha);
    rchk(12'h018, 32'h8010);
    clr();
    pulse(4'h1);
    rchk(12'h018, 32'h10);
    ds_q <= 1'b1;
    pulse(4'h1);
    rchk(12'h018, 32'h8010);
    clr();
    pulse(4'h4);
    rchk(12'h018, 32'h8010);
    // An event that meets a clearing write at its access edge must keep the flag.
    ev_q <= 4'h4;
    apb(1'b1, 12'h018, 32'h0000c100, 4'h2);
    ev_q <= 4'h0;
    rchk(12'h018, 32'h8010);
    clr();
    $display("test events done");
    apb(1'b1, 12'h080, 32'h1, 4'h1);
    rchk(12'h080, 32'h1);
    apb(1'b1, 12'h020, 32'h77, 4'h1);
    rchk(12'h020, 32'h3c);
    apb(1'b1, 12'h080, 32'h0, 4'h1);
    apb(1'b1, 12'h020, 32'h77, 4'h1);
    rchk(12'h020, 32'h77);
    $display("test lock done");
    close_out();
  end
endmodule
`default_nettype wire
